// >>> hw/half_rate_clock.sv
// Divide-by-two bus clock generator with a bus-state advance pulse.
// Assumes the caller holds CLK_EN low to freeze the divider.
`timescale 1ns/10ps
module half_rate_clock (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  output logic clk_out,
  output logic phase_end
);

  // Toggle every enabled edge, giving a 50 percent duty cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_out <= lbus_pkg::RST_CLKOUT;
    end else if (clk_en) begin
      clk_out <= ~clk_out; // R4
    end
  end

  // High in the second half of each bus clock; states advance there
  assign phase_end = clk_out;

endmodule

// >>> hw/lbus_pkg.sv
// Shared types and constants for the multiplexed local bus controller.
// Assumes a single system clock running at twice the bus clock rate.
package lbus_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int HI_ADDR_W = 4;

  // Cycle kind as carried on {addr_data_bit0, upper_byte_lane_n}
  typedef enum logic [1:0] {
    KIND_WORD = 2'h0,
    KIND_EVEN = 2'h1,
    KIND_ODD = 2'h2,
    KIND_REFRESH = 2'h3
  } kind_t;

  // One request from the core side
  typedef struct packed {
    logic write;
    logic is_io;
    kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  // Reset values of the pin drivers, and the default upper region start address
  localparam logic RST_ALE = 1'h0;
  localparam logic RST_STROBE_N = 1'h1;
  localparam logic RST_DIR = 1'h0;
  localparam logic RST_CLKOUT = 1'h0;
  localparam logic [ADDR_W-1:0] RST_UCS_START = 20'hFFC00;

  // Bus clock is the system clock divided by this many
  localparam int CLK_DIV = 2;
  localparam int SYNC_STAGES = 2;

endpackage

// >>> hw/local_bus_interface.sv
// Multiplexed 16-bit local bus master: address latch strobe, byte lane
// status, transceiver control, strobes, upper chip select and bus clock.
// Assumes requests come from logic on CLK_SYS; AD and READY pins are async.
`timescale 1ns/10ps

// Functional notes
// (R1) The address latch strobe is high during the address state of every bus cycle.
// (R2) The upper byte lane enable is low whenever the cycle moves data on the upper byte.
// (R3) Bit 0 and upper lane enable together give 00 word, 01 even, 10 odd, 11 refresh.
// (R4) The bus clock output runs at half the system clock with a 50 percent duty cycle.
// (R5) The outside clock source runs at twice the intended bus rate.
// (R6) The transceiver enable is low only while data is actually on the bus.
// (R7) The direction output is high for transmit and low for receive.
// (R8) The write strobe is low while write data are valid on the bus.
// (R9) The upper select is low for memory cycles whose address lies in the upper region; the code keeps it high for refresh cycles.
// (R10) Direction is set in the address state, before the transceiver enable falls.
module local_bus_interface #(
  parameter logic [lbus_pkg::ADDR_W-1:0] UCS_START_DEFAULT = lbus_pkg::RST_UCS_START
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic [lbus_pkg::ADDR_W-1:0] UCS_START,
  input wire logic REQ_VALID,
  input wire lbus_pkg::req_t REQ,
  output logic REQ_READY,
  output logic DONE,
  output logic [lbus_pkg::DATA_W-1:0] RDATA,
  input wire logic [lbus_pkg::DATA_W-1:0] AD_IN,
  output logic [lbus_pkg::DATA_W-1:0] AD_OUT,
  output logic AD_OE,
  output logic [lbus_pkg::HI_ADDR_W-1:0] A_HI,
  input wire logic READY,
  output logic ADDRESS_LATCH_STROBE,
  output logic UPPER_BYTE_LANE_N,
  output logic TRANSCEIVER_ENABLE_N,
  output logic TRANSFER_DIRECTION,
  output logic WRITE_STROBE_N,
  output logic READ_STROBE_N,
  output logic UPPER_REGION_SELECT_N,
  output logic HALF_RATE_CLOCK_OUT
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_T4
  } state_t;

  state_t state_reg;
  state_t state_next;
  lbus_pkg::req_t req_reg;
  logic phase_end;
  logic adv;
  logic [lbus_pkg::SYNC_STAGES-1:0] ready_sync_reg;
  logic [lbus_pkg::DATA_W-1:0] ad_sync1_reg;
  logic [lbus_pkg::DATA_W-1:0] ad_sync2_reg;
  logic ready_s;
  logic accept;
  logic in_region;
  logic data_phase;
  logic upper_lane;
  logic bit0;

  // Elaboration guard: the pin mapping below is written for these widths only
  if (lbus_pkg::ADDR_W != 20 || lbus_pkg::DATA_W != 16) begin : g_width_check
    $error("local_bus_interface: only a 20-bit address, 16-bit data bus is supported");
  end


  // Bus clock and the advance point of each bus state
  half_rate_clock u_clk (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .clk_en(CLK_EN),
    .clk_out(HALF_RATE_CLOCK_OUT),
    .phase_end(phase_end)
  );

  // States advance and requests are taken only on the late half of the bus clock
  assign adv = CLK_EN & phase_end;
  assign accept = adv & (state_reg == ST_IDLE) & REQ_VALID;

  // Two-stage synchronisers for asynchronous pins
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ready_sync_reg <= '0;
      ad_sync1_reg <= 16'h0000;
      ad_sync2_reg <= 16'h0000;
    end else if (CLK_EN) begin
      ready_sync_reg <= {ready_sync_reg[0], READY};
      ad_sync1_reg <= AD_IN;
      ad_sync2_reg <= ad_sync1_reg;
    end
  end

  // Only the second stage is read, so a metastable first stage never leaks
  assign ready_s = ready_sync_reg[1];

  // Sequencer: one bus state per bus clock, wait states in T3
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (accept) state_next = ST_T1;
      ST_T1: if (adv) state_next = ST_T2;
      ST_T2: if (adv) state_next = ST_T3;
      ST_T3: if (adv && ready_s) state_next = ST_T4;
      ST_T4: if (adv) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // State register, frozen with the clock enable
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
    end else if (CLK_EN) begin
      state_reg <= state_next;
    end
  end

  // Hold the request for the whole cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      req_reg <= '0;
    end else if (accept) begin
      req_reg <= REQ;
    end
  end

  // Decode from the request about to be driven, so pins come from flops
  lbus_pkg::req_t cur;
  assign cur = accept ? REQ : req_reg;
  assign in_region = !cur.is_io && cur.kind != lbus_pkg::KIND_REFRESH
    && cur.addr >= UCS_START;
  assign data_phase = (state_next == ST_T2) || (state_next == ST_T3);
  // Word and odd transfers use the upper lane
  assign upper_lane = cur.kind == lbus_pkg::KIND_WORD || cur.kind == lbus_pkg::KIND_ODD;
  assign bit0 = cur.kind == lbus_pkg::KIND_ODD || cur.kind == lbus_pkg::KIND_REFRESH;

  // Address phase: latch strobe, status pair and upper address
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      ADDRESS_LATCH_STROBE <= lbus_pkg::RST_ALE;
      UPPER_BYTE_LANE_N <= lbus_pkg::RST_STROBE_N;
      A_HI <= 4'h0;
    end else if (CLK_EN) begin
      ADDRESS_LATCH_STROBE <= state_next == ST_T1; // R1
      if (state_next == ST_T1) begin
        UPPER_BYTE_LANE_N <= ~upper_lane; // R2 R3
        A_HI <= cur.addr[19:16];
      end else if (state_next == ST_IDLE) begin
        UPPER_BYTE_LANE_N <= lbus_pkg::RST_STROBE_N;
      end
    end
  end

  // Multiplexed AD drivers: address in T1, write data in T2..T4
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      AD_OUT <= 16'h0000;
      AD_OE <= 1'h0;
    end else if (CLK_EN) begin
      if (state_next == ST_T1) begin
        AD_OUT <= {cur.addr[15:1], bit0}; // R3
        AD_OE <= 1'h1;
      end else if (state_next != ST_IDLE && cur.write) begin
        AD_OUT <= cur.wdata; // R8
        AD_OE <= 1'h1;
      end else begin
        AD_OE <= 1'h0;
      end
    end
  end

  // Transceiver control; direction settles in T1, enable follows in T2
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      TRANSCEIVER_ENABLE_N <= lbus_pkg::RST_STROBE_N;
      TRANSFER_DIRECTION <= lbus_pkg::RST_DIR;
    end else if (CLK_EN) begin
      // Refresh moves no data, so buffers stay off
      TRANSCEIVER_ENABLE_N <= ~(data_phase && cur.kind != lbus_pkg::KIND_REFRESH); // R6
      if (state_next == ST_T1) begin
        TRANSFER_DIRECTION <= cur.write; // R7 R10
      end else if (state_next == ST_IDLE) begin
        TRANSFER_DIRECTION <= lbus_pkg::RST_DIR; // R10
      end
    end
  end

  // Strobes and upper select
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      WRITE_STROBE_N <= lbus_pkg::RST_STROBE_N;
      READ_STROBE_N <= lbus_pkg::RST_STROBE_N;
      UPPER_REGION_SELECT_N <= lbus_pkg::RST_STROBE_N;
    end else if (CLK_EN) begin
      WRITE_STROBE_N <= ~(data_phase && cur.write); // R8
      READ_STROBE_N <= ~(data_phase && !cur.write);
      UPPER_REGION_SELECT_N <= ~(state_next != ST_IDLE && in_region); // R9
    end
  end

  // Core handshake; read data taken from the synchronised pins at T3 exit
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      REQ_READY <= 1'h0;
      DONE <= 1'h0;
      RDATA <= 16'h0000;
    end else if (CLK_EN) begin
      REQ_READY <= state_next == ST_IDLE && !phase_end;
      DONE <= state_reg == ST_T4 && adv;
      if (state_reg == ST_T3 && state_next == ST_T4 && !req_reg.write) begin
        RDATA <= ad_sync2_reg;
      end
    end else begin
      DONE <= 1'h0;
    end
  end

endmodule

// >>> verif/lbus_chk_asserts.sv
// Pin checker for the local bus master, bound to its top module.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/10ps
module lbus_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic [15:0] AD_OUT,
  input wire logic ADDRESS_LATCH_STROBE,
  input wire logic UPPER_BYTE_LANE_N,
  input wire logic TRANSCEIVER_ENABLE_N,
  input wire logic TRANSFER_DIRECTION,
  input wire logic WRITE_STROBE_N,
  input wire logic READ_STROBE_N,
  input wire logic HALF_RATE_CLOCK_OUT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // Strobe timing, direction and status relations
  a_ale_one_state: assert property ($rose(ADDRESS_LATCH_STROBE) |=>
    ADDRESS_LATCH_STROBE ##1 !ADDRESS_LATCH_STROBE) else $error("ale");
  a_clk_halves: assert property (CLK_EN |=> $changed(HALF_RATE_CLOCK_OUT)) else $error("ck");
  a_den_in_data: assert property (!TRANSCEIVER_ENABLE_N |->
    !ADDRESS_LATCH_STROBE && WRITE_STROBE_N != READ_STROBE_N) else $error("den");
  a_dir_set_early: assert property ($fell(TRANSCEIVER_ENABLE_N) |->
    $past(TRANSFER_DIRECTION, 2) == TRANSFER_DIRECTION) else $error("dir");
  a_dir_on_write: assert property (!WRITE_STROBE_N |-> TRANSFER_DIRECTION) else $error("dw");
  a_dir_on_read: assert property (!READ_STROBE_N |-> !TRANSFER_DIRECTION) else $error("dr");
  a_wr_data_held: assert property (!WRITE_STROBE_N && !$past(WRITE_STROBE_N) |->
    $stable(AD_OUT)) else $error("wd");
  a_refresh_code: assert property ($rose(ADDRESS_LATCH_STROBE) && AD_OUT[0] &&
    UPPER_BYTE_LANE_N |-> ##2 TRANSCEIVER_ENABLE_N && !READ_STROBE_N) else $error("rf");
  c_write: cover property ($fell(WRITE_STROBE_N));
  c_read: cover property ($fell(READ_STROBE_N) && !TRANSCEIVER_ENABLE_N);
  c_refresh: cover property ($fell(READ_STROBE_N) && TRANSCEIVER_ENABLE_N);
endmodule
bind local_bus_interface lbus_chk u_lbus_chk (.CLK_SYS, .RST_N, .CLK_EN, .AD_OUT,
  .ADDRESS_LATCH_STROBE, .UPPER_BYTE_LANE_N, .TRANSCEIVER_ENABLE_N, .TRANSFER_DIRECTION,
  .WRITE_STROBE_N, .READ_STROBE_N, .HALF_RATE_CLOCK_OUT);

// >>> verif/lbus_mem.sv
// Memory device on the far side of the bus; answers after set waits.
// Assumes strobes and address come straight from the master's pins.
`timescale 1ns/10ps
module lbus_mem (
  input wire logic clk,
  input wire logic ale,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [15:0] ad_out,
  input wire logic [3:0] waits,
  output logic [15:0] ad_in = 16'h5A5A,
  output logic ready = 1'h0
);
  logic [15:0] mem_reg [0:255];
  logic [7:0] addr_reg;
  int cnt_reg = 0;
  // Released bus shows inverted junk so stale data never passes
  always @(posedge clk) begin
    if (ale) addr_reg <= ad_out[8:1];
    if (!wr_n) mem_reg[addr_reg] <= ad_out;
    cnt_reg <= (wr_n && rd_n) ? 0 : cnt_reg + 1;
    ready <= (!wr_n || !rd_n) && cnt_reg >= waits;
    ad_in <= rd_n ? ~ad_in : mem_reg[addr_reg];
  end
endmodule

// >>> verif/local_bus_interface_tb_top.sv
// Bench for the local bus master with a memory model on its pins.
// Assumes the pin checker binds itself to the design.
`timescale 1ns/10ps
module local_bus_interface_tb_top;
  logic clk = 1'h0, rst_n = 1'h0, vld = 1'h0, rdy, done, ale, bhe_n, den_n, dir;
  logic wr_n, rd_n, ucs_n, ready;
  logic [15:0] ad_in, ad_out, rdata;
  logic [3:0] waits = 4'h0;
  logic [6:0] obs;
  logic [3:0] a_hi, hi_seen;
  logic cen = 1'h1, hclk, oe, oe_seen;
  lbus_pkg::req_t req = '0;
  int mismatches = 0, checks_done = 0;
  always #50 clk = ~clk;
  local_bus_interface u_local_bus_interface (.CLK_SYS(clk), .RST_N(rst_n), .CLK_EN(cen),
    .UCS_START(20'hFFC00), .REQ_VALID(vld), .REQ(req), .REQ_READY(rdy), .DONE(done),
    .RDATA(rdata), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE(oe), .A_HI(a_hi), .READY(ready),
    .ADDRESS_LATCH_STROBE(ale), .UPPER_BYTE_LANE_N(bhe_n), .TRANSCEIVER_ENABLE_N(den_n),
    .TRANSFER_DIRECTION(dir), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
    .UPPER_REGION_SELECT_N(ucs_n), .HALF_RATE_CLOCK_OUT(hclk));
  lbus_mem u_lbus_mem (.clk(clk), .ale(ale), .wr_n(wr_n), .rd_n(rd_n), .ad_out(ad_out),
    .waits(waits), .ad_in(ad_in), .ready(ready));
  task automatic check(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %h not %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One bus cycle; obs keeps T1 status and which strobes went low
  task automatic xfer(input lbus_pkg::req_t r);
    int n = 0;
    obs = 7'h00;
    oe_seen = ~r.write;
    hi_seen = ~r.addr[19:16];
    vld = 1'h1;
    req = r;
    while (rdy !== 1'h1 && n++ < 40) @(negedge clk);
    @(negedge clk);
    vld = 1'h0;
    do begin
      @(negedge clk);
      if (ale === 1'h1) begin
        obs[6:3] = {ad_out[0], bhe_n, ucs_n, dir};
        hi_seen = a_hi;
      end
      // Drive enable must follow the direction while a strobe is low
      if (rd_n === 1'h0 || wr_n === 1'h0) oe_seen = oe;
      obs[2:0] = obs[2:0] | {~den_n, ~rd_n, ~wr_n};
    end while (done !== 1'h1 && n++ < 80);
    if (done !== 1'h1) begin
      mismatches++;
      summarize();
    end
  endtask
  // Every kind, even and refresh ones just under the upper region boundary
  task automatic t_kinds;
    for (int k = 0; k < 4; k++) begin
      xfer({2'h0, 2'(k), k[0] ? 20'hFFBFE : 20'hFFC00, 16'h0000});
      check(16'(obs), {9'h0, 2'(k), k[0], 1'h0, k != 3, 2'h2});
      check(16'({hi_seen, oe_seen}), 16'h001E);
    end
    // I/O cycles never select the upper region, even at a high address
    xfer({2'h1, lbus_pkg::KIND_WORD, 20'hFFC00, 16'h0000});
    check(16'(obs), 16'h0016);
    check(16'({hi_seen, oe_seen}), 16'h001E);
  endtask
  // Write, then read back slowly; the memory waits three cycles, giving two wait states
  task automatic t_write_read;
    xfer({2'h2, lbus_pkg::KIND_WORD, 20'h00024, 16'hA5C3});
    check(16'(obs), 16'h001D);
    check(16'({hi_seen, oe_seen}), 16'h0001);
    waits = 4'h3;
    xfer({2'h0, lbus_pkg::KIND_WORD, 20'h00024, 16'h0000});
    check(16'(obs), 16'h0016);
    check(16'({hi_seen, oe_seen}), 16'h0000);
    check(rdata, 16'hA5C3);
  endtask
  // Enable low freezes bus clock and REQ_READY; the clock resumes toggling after
  task automatic t_freeze;
    logic [1:0] held;
    held = {hclk, rdy};
    cen = 1'h0;
    repeat (3) @(negedge clk);
    check(16'({hclk, rdy}), 16'(held));
    cen = 1'h1;
    @(negedge clk);
    check(16'(hclk), {15'h0, !held[1]});
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) @(negedge clk);
    t_kinds();
    t_freeze();
    t_write_read();
    summarize();
  end
endmodule
